//--- inc/oad_pkg.sv
// Package for the operand address decoder: encodings, bank codes and carriers
package oad_pkg;
  // Effective address field boundaries
  localparam logic [4:0] EA_IND_BASE   = 5'h08;
  localparam logic [4:0] EA_POST_BASE  = 5'h0C;
  localparam logic [4:0] EA_D8_BASE    = 5'h10;
  localparam logic [4:0] EA_D16_BASE   = 5'h18;
  localparam logic [4:0] EA_IDX0       = 5'h1C;
  localparam logic [4:0] EA_IDX1       = 5'h1D;
  localparam logic [4:0] EA_PCREL      = 5'h1E;
  localparam logic [4:0] EA_DIRECT     = 5'h1F;
  // Index register used by base-plus-index forms
  localparam logic [2:0] IDX_REG       = 3'h7;
  // Number of distinct addressing modes
  localparam int         MODE_COUNT    = 23;
  // Post-increment steps by operand size
  localparam logic [15:0] INC_BYTE     = 16'h0001;
  localparam logic [15:0] INC_WORD     = 16'h0002;
  localparam logic [15:0] INC_LONG     = 16'h0004;
  // I/O direct page bank and page
  localparam logic [7:0] IO_BANK       = 8'h00;
  localparam logic [7:0] IO_PAGE       = 8'h00;
  // Reset values
  localparam logic [23:0] ADDR_RESET   = 24'h00_0000;
  localparam logic [31:0] IMM_RESET    = 32'h0000_0000;

  // Operand size
  typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10} oad_size_t;
  // Immediate size
  typedef enum logic [1:0] {IM_4 = 2'b00, IM_8 = 2'b01, IM_16 = 2'b10, IM_32 = 2'b11} oad_imm_t;
  // Bank selected for a memory address
  typedef enum logic [2:0] {
    BK_NONE = 3'd0, BK_DATA = 3'd1, BK_EXTRA = 3'd2, BK_STACK = 3'd3, BK_CODE = 3'd4,
    BK_IO = 3'd5
  } oad_bank_t;
  // Addressing modes (23 of them)
  typedef enum logic [4:0] {
    AM_IMM, AM_REG, AM_BR16, AM_BR24, AM_IO, AM_DIR, AM_ADDR16, AM_IOBIT, AM_DIRBIT,
    AM_ADDRBIT, AM_VECT, AM_IND, AM_POSTINC, AM_DISP, AM_LONGDISP, AM_PCDISP, AM_BASEIDX,
    AM_REL, AM_RLIST, AM_ACCIND, AM_ACCBR, AM_EARBR, AM_EAMBR
  } oad_mode_t;
  // Decoder request from instruction decode
  typedef struct packed {
    logic      valid;
    logic      implied;
    oad_mode_t impliedMode;
    logic [4:0] eaCode;
    oad_size_t size;
    oad_imm_t  immSize;
    logic [31:0] extWord;
    logic      accLoadShift;
  } oad_req_t;
  // Current core register values used for addressing
  typedef struct packed {
    logic [15:0] wordReg0;
    logic [15:0] wordReg1;
    logic [15:0] wordReg2;
    logic [15:0] wordReg3;
    logic [15:0] wordReg4;
    logic [15:0] wordReg5;
    logic [15:0] wordReg6;
    logic [15:0] wordReg7;
    logic [15:0] programCounter;
    logic [7:0]  codeBankReg;
    logic [7:0]  dataBankReg;
    logic [7:0]  extraDataBankReg;
    logic [7:0]  userStackBank;
    logic [7:0]  systemStackBank;
    logic [7:0]  directPageReg;
    logic [15:0] userStackPointer;
    logic [15:0] systemStackPointer;
    logic        stackSelect;
    logic [15:0] accumulatorLow;
  } oad_regs_t;
  // Decoded operand result
  typedef struct packed {
    logic        valid;
    oad_mode_t   mode;
    logic        isReg;
    logic [2:0]  regIdx;
    logic        isMem;
    logic [23:0] memAddr;
    oad_bank_t   bank;
    logic        ptrWrite;
    logic [2:0]  ptrIdx;
    logic [15:0] ptrValue;
    logic [31:0] immValue;
    logic [15:0] stackPtr;
    logic        branch;
    logic [15:0] newPc;
    logic [7:0]  newCodeBank;
    logic        accShift;
    logic [15:0] accHighValue;
  } oad_res_t;
endpackage

//--- hw/oad_bank_sel.sv
// Default bank selection for indirect operands
`timescale 1ns/1ns
module oad_bank_sel (
  input  wire logic [2:0]         ptrIdx,       // Word register used as pointer
  input  wire oad_pkg::oad_regs_t regs,         // Core register values
  output oad_pkg::oad_bank_t      bankSel,      // Bank kind chosen
  output logic [7:0]              bankValue     // Bank value, address bits 23..16
);
  // Registers 0,1,4,5 data; 2,6 extra; 3,7 stack
  always_comb begin
    case (ptrIdx[1:0])
      2'd2: begin
        bankSel   = oad_pkg::BK_EXTRA; // RULE_04
        bankValue = regs.extraDataBankReg;
      end
      2'd3: begin
        bankSel   = oad_pkg::BK_STACK; // RULE_04
        bankValue = regs.stackSelect ? regs.systemStackBank : regs.userStackBank; // RULE_16
      end
      default: begin
        bankSel   = oad_pkg::BK_DATA; // RULE_04
        bankValue = regs.dataBankReg;
      end
    endcase
  end
endmodule

//--- hw/oad_decode.sv
// Operand address decoder: effective address field, immediates, branches
`timescale 1ns/1ns
// Functional notes
// (RULE_01) Addressing format comes from the effective address field or implied opcode.
// (RULE_02) Exactly 23 operand and branch addressing modes are supported.
// (RULE_03) Codes 00-07 are register direct; long uses code/2; no bank.
// (RULE_04) 08-1B indirect forms; pointers 0145 data, 26 extra, 37 stack bank.
// (RULE_05) Codes 1C/1D address word reg 0/1 plus reg 7, data bank.
// (RULE_06) 1E is PC plus 16-bit displacement, code bank; 1F direct, data bank.
// (RULE_07) Immediates are 4, 8, 16 or 32 bits as the opcode requires.
// (RULE_08) Register operands include general, accumulator, pointer, bank and status registers; the decoder only gives word register index 0-7.
// (RULE_09) Stack pointer operand picks user or system pointer by stack select flag.
// (RULE_10) Branches act on the program counter implicitly.
// (RULE_11) 16-bit direct branch loads PC and keeps the code bank.
// (RULE_12) 24-bit branch loads PC low 16 bits and code bank upper 8.
// (RULE_13) Jump, call and software interrupt accept both direct branch forms.
// (RULE_14) Some accumulator loads copy old low word into high word first.
// (RULE_15) Post increment adds 1, 2 or 4 by operand size.
// (RULE_16) Pointer register 3 uses system or user stack bank by flag.
// (RULE_17) I/O direct reaches 000000-0000FF, ignoring data bank and page.
// (RULE_18) Every memory address is bank value joined with 16-bit offset.
module oad_decode (
  input  wire logic               mclk,     // Core clock, 25 MHz
  input  wire logic               rst,      // Asynchronous reset, active high
  input  wire oad_pkg::oad_req_t  req,      // Operand request from decode
  input  wire oad_pkg::oad_regs_t regs,     // Current core registers
  output oad_pkg::oad_res_t       res       // Registered decode result
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] wordSel(input oad_pkg::oad_regs_t r, input logic [2:0] i);
    case (i)
      3'd0:    wordSel = r.wordReg0;
      3'd1:    wordSel = r.wordReg1;
      3'd2:    wordSel = r.wordReg2;
      3'd3:    wordSel = r.wordReg3;
      3'd4:    wordSel = r.wordReg4;
      3'd5:    wordSel = r.wordReg5;
      3'd6:    wordSel = r.wordReg6;
      default: wordSel = r.wordReg7;
    endcase
  endfunction

  function automatic logic [23:0] joinAddr(input logic [7:0] bk, input logic [15:0] off);
    joinAddr = {bk, off}; // RULE_18
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pointer register choice and its default bank
  logic [2:0]         ptrIdx;
  oad_pkg::oad_bank_t ptrBank;
  logic [7:0]         ptrBankValue;

  // Displaced form 10-17 uses three index bits; others use two
  always_comb begin
    if (req.eaCode[4:3] == 2'b10) begin
      ptrIdx = req.eaCode[2:0];
    end else if (req.eaCode == oad_pkg::EA_IDX1) begin
      ptrIdx = 3'd1;
    end else begin
      ptrIdx = {1'b0, req.eaCode[1:0]};
    end
  end

  oad_bank_sel uBankSel (
    .ptrIdx    (ptrIdx),
    .regs      (regs),
    .bankSel   (ptrBank),
    .bankValue (ptrBankValue)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-value computation
  oad_pkg::oad_res_t res_reg;
  oad_pkg::oad_res_t res_next;
  logic [15:0]       ptrWord;
  logic [15:0]       incStep;
  logic [15:0]       disp8Ext;

  always_comb begin
    ptrWord  = wordSel(regs, ptrIdx);
    disp8Ext = {{8{req.extWord[7]}}, req.extWord[7:0]};
    case (req.size)
      oad_pkg::SZ_BYTE: incStep = oad_pkg::INC_BYTE; // RULE_15
      oad_pkg::SZ_WORD: incStep = oad_pkg::INC_WORD; // RULE_15
      default:          incStep = oad_pkg::INC_LONG; // RULE_15
    endcase
  end

  // Main decode of mode, address, immediates and branch targets
  always_comb begin
    res_next              = '0;
    res_next.valid        = req.valid;
    res_next.bank         = oad_pkg::BK_NONE;
    // Stack pointer operand resolved up front
    res_next.stackPtr     = regs.stackSelect ? regs.systemStackPointer
                                             : regs.userStackPointer; // RULE_09
    if (!req.implied) begin // RULE_01
      if (req.eaCode < oad_pkg::EA_IND_BASE) begin
        res_next.mode   = oad_pkg::AM_REG; // RULE_03
        res_next.isReg  = 1'b1;
        // Long operands pair word registers, so code/2 names the pair
        res_next.regIdx = (req.size == oad_pkg::SZ_LONG) ? {1'b0, req.eaCode[2:1]}
                                                         : req.eaCode[2:0]; // RULE_03
      end else begin
        res_next.isMem = 1'b1;
        res_next.bank  = ptrBank;
        if (req.eaCode < oad_pkg::EA_POST_BASE) begin
          res_next.mode    = oad_pkg::AM_IND;
          res_next.memAddr = joinAddr(ptrBankValue, ptrWord); // RULE_04
        end else if (req.eaCode < oad_pkg::EA_D8_BASE) begin
          res_next.mode     = oad_pkg::AM_POSTINC;
          res_next.memAddr  = joinAddr(ptrBankValue, ptrWord); // RULE_04
          res_next.ptrWrite = 1'b1;
          res_next.ptrIdx   = ptrIdx;
          res_next.ptrValue = ptrWord + incStep; // RULE_15
        end else if (req.eaCode < oad_pkg::EA_D16_BASE) begin
          res_next.mode    = oad_pkg::AM_DISP;
          res_next.memAddr = joinAddr(ptrBankValue, ptrWord + disp8Ext); // RULE_04
        end else if (req.eaCode < oad_pkg::EA_IDX0) begin
          res_next.mode    = oad_pkg::AM_DISP;
          res_next.memAddr = joinAddr(ptrBankValue, ptrWord + req.extWord[15:0]); // RULE_04
        end else if (req.eaCode == oad_pkg::EA_PCREL) begin
          res_next.mode    = oad_pkg::AM_PCDISP;
          res_next.bank    = oad_pkg::BK_CODE;
          res_next.memAddr = joinAddr(regs.codeBankReg,
                                      regs.programCounter + req.extWord[15:0]); // RULE_06
        end else if (req.eaCode == oad_pkg::EA_DIRECT) begin
          res_next.mode    = oad_pkg::AM_ADDR16;
          res_next.bank    = oad_pkg::BK_DATA;
          res_next.memAddr = joinAddr(regs.dataBankReg, req.extWord[15:0]); // RULE_06
        end else begin
          // Base plus index always uses the data bank, not the pointer's bank
          res_next.mode    = oad_pkg::AM_BASEIDX;
          res_next.bank    = oad_pkg::BK_DATA;
          res_next.memAddr = joinAddr(regs.dataBankReg,
                                      ptrWord + wordSel(regs, oad_pkg::IDX_REG)); // RULE_05
        end
      end
    end else begin
      res_next.mode = req.impliedMode; // RULE_01 RULE_02
      case (req.impliedMode)
        oad_pkg::AM_IMM: begin
          case (req.immSize) // RULE_07
            oad_pkg::IM_4:  res_next.immValue = {28'h000_0000, req.extWord[3:0]};
            oad_pkg::IM_8:  res_next.immValue = {24'h00_0000, req.extWord[7:0]};
            oad_pkg::IM_16: res_next.immValue = {16'h0000, req.extWord[15:0]};
            default:        res_next.immValue = req.extWord;
          endcase
          // Old low accumulator word moves up on shifting loads
          res_next.accShift     = req.accLoadShift; // RULE_14
          res_next.accHighValue = regs.accumulatorLow; // RULE_14
        end
        oad_pkg::AM_BR16: begin
          res_next.branch      = 1'b1; // RULE_10 RULE_13
          res_next.newPc       = req.extWord[15:0]; // RULE_11
          res_next.newCodeBank = regs.codeBankReg; // RULE_11
        end
        oad_pkg::AM_BR24: begin
          res_next.branch      = 1'b1; // RULE_10 RULE_13
          res_next.newPc       = req.extWord[15:0]; // RULE_12
          res_next.newCodeBank = req.extWord[23:16]; // RULE_12
        end
        oad_pkg::AM_IO, oad_pkg::AM_IOBIT: begin
          res_next.isMem   = 1'b1;
          res_next.bank    = oad_pkg::BK_IO;
          res_next.memAddr = joinAddr(oad_pkg::IO_BANK,
                                      {oad_pkg::IO_PAGE, req.extWord[7:0]}); // RULE_17
        end
        oad_pkg::AM_DIR, oad_pkg::AM_DIRBIT: begin
          res_next.isMem   = 1'b1;
          res_next.bank    = oad_pkg::BK_DATA;
          res_next.memAddr = joinAddr(regs.dataBankReg,
                                      {regs.directPageReg, req.extWord[7:0]});
        end
        oad_pkg::AM_ADDR16, oad_pkg::AM_ADDRBIT: begin
          res_next.isMem   = 1'b1;
          res_next.bank    = oad_pkg::BK_DATA;
          res_next.memAddr = joinAddr(regs.dataBankReg, req.extWord[15:0]);
        end
        oad_pkg::AM_REG: begin
          res_next.isReg  = 1'b1; // RULE_08
          res_next.regIdx = req.eaCode[2:0];
        end
        default: begin
          // Remaining modes are carried through for the execution stage
          res_next.mode = req.impliedMode;
        end
      endcase
    end
    if (!req.valid) begin
      res_next = '0;
    end
  end

  // Result register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      res_reg <= '0;
    end else begin
      res_reg <= res_next;
    end
  end

  assign res = res_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode list must hold exactly the documented number of modes
  if (int'(oad_pkg::AM_EAMBR) != oad_pkg::MODE_COUNT - 1) begin : gModeCount // RULE_02
    $error("addressing mode list does not match mode count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  regAddrNoBank_a: assert property (@(posedge mclk) disable iff (rst) // RULE_03
    (req.valid && !req.implied && req.eaCode < 5'h08) |=> (res.isReg && !res.isMem))
    else $error("register direct code produced memory access");
  postIncStep_a: assert property (@(posedge mclk) disable iff (rst) // RULE_15
    (req.valid && !req.implied && req.eaCode[4:2] == 3'b011 && req.size == oad_pkg::SZ_WORD)
    |=> (res.ptrValue == res.memAddr[15:0] + 16'h0002))
    else $error("post increment step wrong for word");
  baseIdxBank_a: assert property (@(posedge mclk) disable iff (rst) // RULE_05
    (req.valid && !req.implied && req.eaCode[4:1] == 4'b1110)
    |=> (res.memAddr[23:16] == $past(regs.dataBankReg)))
    else $error("base index bank not data bank");
  pcRelBank_a: assert property (@(posedge mclk) disable iff (rst) // RULE_06
    (req.valid && !req.implied && req.eaCode == 5'h1E)
    |=> (res.memAddr[23:16] == $past(regs.codeBankReg) && res.bank == oad_pkg::BK_CODE))
    else $error("pc relative bank wrong");
  stackSel_a: assert property (@(posedge mclk) disable iff (rst) // RULE_09
    ($past(regs.stackSelect) == 1'b1 && $past(req.valid))
    |-> (res.stackPtr == $past(regs.systemStackPointer)))
    else $error("stack pointer selection wrong");
  br16Bank_a: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    (req.valid && req.implied && req.impliedMode == oad_pkg::AM_BR16)
    |=> (res.branch && res.newCodeBank == $past(regs.codeBankReg)))
    else $error("short branch changed bank");
  br24Bank_a: assert property (@(posedge mclk) disable iff (rst) // RULE_12
    (req.valid && req.implied && req.impliedMode == oad_pkg::AM_BR24)
    |=> (res.newCodeBank == $past(req.extWord[23:16]) && res.newPc == $past(req.extWord[15:0])))
    else $error("long branch target wrong");
  ioRange_a: assert property (@(posedge mclk) disable iff (rst) // RULE_17
    (res.valid && res.bank == oad_pkg::BK_IO) |-> (res.memAddr[23:8] == 16'h0000))
    else $error("io address outside first page");
  stackBank_a: assert property (@(posedge mclk) disable iff (rst) // RULE_16
    (req.valid && !req.implied && req.eaCode == 5'h0B && !regs.stackSelect)
    |=> (res.memAddr[23:16] == $past(regs.userStackBank)))
    else $error("stack bank selection wrong");
  accShift_a: assert property (@(posedge mclk) disable iff (rst) // RULE_14
    (req.valid && req.implied && req.impliedMode == oad_pkg::AM_IMM && req.accLoadShift)
    |=> (res.accShift && res.accHighValue == $past(regs.accumulatorLow)))
    else $error("accumulator shift value wrong");

  // Further guards: banks, direct forms, immediates, branches, idle cycles

  extraBank_a: assert property (@(posedge mclk) disable iff (rst) // RULE_04
    (req.valid && !req.implied && req.eaCode == 5'h0A)
    |=> (res.memAddr[23:16] == $past(regs.extraDataBankReg) && res.bank == oad_pkg::BK_EXTRA))
    else $error("pointer two missed the extra bank");

  longRegIdx_a: assert property (@(posedge mclk) disable iff (rst) // RULE_03
    (req.valid && !req.implied && req.eaCode < 5'h08 && req.size == oad_pkg::SZ_LONG)
    |=> (res.regIdx == {1'b0, $past(req.eaCode[2:1])}))
    else $error("long register pair index wrong");

  directAddr_a: assert property (@(posedge mclk) disable iff (rst) // RULE_06
    (req.valid && !req.implied && req.eaCode == 5'h1F)
    |=> (res.memAddr == {$past(regs.dataBankReg), $past(req.extWord[15:0])}))
    else $error("direct address not in data bank");

  dirJoin_a: assert property (@(posedge mclk) disable iff (rst) // RULE_18
    (req.valid && req.implied && req.impliedMode == oad_pkg::AM_DIR)
    |=> (res.memAddr == {$past(regs.dataBankReg), $past(regs.directPageReg),
                         $past(req.extWord[7:0])}))
    else $error("short direct address joined wrong");

  immNibble_a: assert property (@(posedge mclk) disable iff (rst) // RULE_07
    (req.valid && req.implied && req.impliedMode == oad_pkg::AM_IMM
     && req.immSize == oad_pkg::IM_4)
    |=> (res.immValue == {28'h000_0000, $past(req.extWord[3:0])}))
    else $error("four bit immediate not zero extended");

  branchMode_a: assert property (@(posedge mclk) disable iff (rst) // RULE_10 RULE_13
    res.branch |-> (res.valid && (res.mode == oad_pkg::AM_BR16 || res.mode == oad_pkg::AM_BR24)))
    else $error("branch raised outside direct branch modes");

  postIncOnly_a: assert property (@(posedge mclk) disable iff (rst) // RULE_15
    res.ptrWrite |-> (res.mode == oad_pkg::AM_POSTINC && res.isMem))
    else $error("pointer write outside post increment");

  idleZero_a: assert property (@(posedge mclk) disable iff (rst) // RULE_01
    !req.valid |=> (res == '0))
    else $error("idle cycle left a result");

  userStack_a: assert property (@(posedge mclk) disable iff (rst) // RULE_09
    (req.valid && !regs.stackSelect) |=> (res.stackPtr == $past(regs.userStackPointer)))
    else $error("user stack pointer not selected");

  postIncSeen_c: cover property (@(posedge mclk) disable iff (rst)
    res.valid && res.mode == oad_pkg::AM_POSTINC);
  br24Seen_c: cover property (@(posedge mclk) disable iff (rst)
    res.valid && res.mode == oad_pkg::AM_BR24);
  baseIdxSeen_c: cover property (@(posedge mclk) disable iff (rst)
    res.valid && res.mode == oad_pkg::AM_BASEIDX);
  ioSeen_c: cover property (@(posedge mclk) disable iff (rst)
    res.valid && res.mode == oad_pkg::AM_IO);
  dispSeen_c: cover property (@(posedge mclk) disable iff (rst)
    res.valid && res.mode == oad_pkg::AM_DISP);
endmodule

//--- testbench/test_cpu_operand_address_decode.sv
// Self-checking bench for the operand address decoder
`timescale 1ns/1ns
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_cpu_operand_address_decode;
  logic               mclk;      // Core clock, 40 ns period
  logic               rst;       // Asynchronous reset, active high
  oad_pkg::oad_req_t  req;       // Request into the decoder
  oad_pkg::oad_regs_t regsIn;    // Core register snapshot
  oad_pkg::oad_res_t  res;       // Registered result
  oad_pkg::oad_req_t  prevReq;   // Request the current result belongs to
  oad_pkg::oad_regs_t prevRegs;  // Registers the current result belongs to
  int                 seed;      // Fixed random seed
  int                 errTotal;  // Mismatch count
  int                 testsRun;  // Comparison count
  oad_pkg::oad_mode_t modes [10]; // Implied modes exercised

  oad_decode DUT (
    .mclk (mclk),
    .rst  (rst),
    .req  (req),
    .regs (regsIn),
    .res  (res)
  );

  // Free-running clock
  always #20 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Expectation helpers

  // Random register snapshot; every field gets fresh bits
  function automatic oad_pkg::oad_regs_t rand_regs();
    logic [255:0] b;
    for (int i = 0; i < 8; i++) begin
      b[i*32 +: 32] = $random(seed);
    end
    return oad_pkg::oad_regs_t'(b[$bits(oad_pkg::oad_regs_t)-1:0]);
  endfunction

  // Random legal request; size kept to the three encodings the decoder knows
  function automatic oad_pkg::oad_req_t rand_req();
    oad_pkg::oad_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.eaCode = 5'($random(seed));
    r.size = oad_pkg::oad_size_t'(2'($unsigned($random(seed)) % 3));
    r.immSize = oad_pkg::oad_imm_t'(2'($random(seed)));
    r.extWord = $random(seed);
    r.accLoadShift = 1'($random(seed));
    return r;
  endfunction

  // Compare the result against what the request and registers demand
  task automatic check_res(input oad_pkg::oad_req_t r, input oad_pkg::oad_regs_t g);
    logic [15:0]        w [8];
    logic [15:0]        off;
    logic [15:0]        inc;
    logic [7:0]         bk;
    logic [2:0]         p;
    logic [4:0]         c;
    logic [31:0]        im;
    oad_pkg::oad_bank_t bs;
    oad_pkg::oad_mode_t md;
    w = '{g.wordReg0, g.wordReg1, g.wordReg2, g.wordReg3,
          g.wordReg4, g.wordReg5, g.wordReg6, g.wordReg7};
    c = r.eaCode;
    if (!r.valid) begin
      `CHK("idle", oad_pkg::oad_res_t'(0), res)
      return;
    end
    `CHK("valid", 1'b1, res.valid)
    `CHK("stackPtr", g.stackSelect ? g.systemStackPointer : g.userStackPointer, res.stackPtr)
    if (r.implied) begin
      `CHK("mode", r.impliedMode, res.mode)
      case (r.impliedMode)
        oad_pkg::AM_BR16: begin
          `CHK("branch", 1'b1, res.branch)
          `CHK("newPc", r.extWord[15:0], res.newPc)
          `CHK("newCodeBank", g.codeBankReg, res.newCodeBank)
        end
        oad_pkg::AM_BR24: begin
          `CHK("branch", 1'b1, res.branch)
          `CHK("newPc", r.extWord[15:0], res.newPc)
          `CHK("newCodeBank", r.extWord[23:16], res.newCodeBank)
        end
        oad_pkg::AM_IO, oad_pkg::AM_IOBIT: begin
          `CHK("ioAddr", {16'h0000, r.extWord[7:0]}, res.memAddr)
          `CHK("ioBank", oad_pkg::BK_IO, res.bank)
        end
        oad_pkg::AM_DIR, oad_pkg::AM_DIRBIT: begin
          `CHK("dirAddr", {g.dataBankReg, g.directPageReg, r.extWord[7:0]}, res.memAddr)
        end
        oad_pkg::AM_ADDR16, oad_pkg::AM_ADDRBIT: begin
          `CHK("addrAddr", {g.dataBankReg, r.extWord[15:0]}, res.memAddr)
        end
        oad_pkg::AM_IMM: begin
          case (r.immSize)
            oad_pkg::IM_4:  im = {28'h000_0000, r.extWord[3:0]};
            oad_pkg::IM_8:  im = {24'h00_0000, r.extWord[7:0]};
            oad_pkg::IM_16: im = {16'h0000, r.extWord[15:0]};
            default:        im = r.extWord;
          endcase
          `CHK("immValue", im, res.immValue)
          `CHK("accShift", r.accLoadShift, res.accShift)
          if (r.accLoadShift) begin
            `CHK("accHigh", g.accumulatorLow, res.accHighValue)
          end
        end
        default: begin
          `CHK("isReg", 1'b1, res.isReg)
          `CHK("regIdx", c[2:0], res.regIdx)
        end
      endcase
      return;
    end
    if (c < 5'h08) begin
      `CHK("mode", oad_pkg::AM_REG, res.mode)
      `CHK("isReg", 1'b1, res.isReg)
      `CHK("isMem", 1'b0, res.isMem)
      `CHK("regIdx", (r.size == oad_pkg::SZ_LONG) ? {1'b0, c[2:1]} : c[2:0], res.regIdx)
      `CHK("bank", oad_pkg::BK_NONE, res.bank)
      return;
    end
    // Pointer index and offset by code range
    p = {1'b0, c[1:0]};
    off = w[p];
    if (c < 5'h0C) begin
      md = oad_pkg::AM_IND;
    end else if (c < 5'h10) begin
      md = oad_pkg::AM_POSTINC;
    end else if (c < 5'h18) begin
      md = oad_pkg::AM_DISP;
      p = c[2:0];
      off = w[p] + {{8{r.extWord[7]}}, r.extWord[7:0]};
    end else if (c < 5'h1C) begin
      md = oad_pkg::AM_DISP;
      off = w[p] + r.extWord[15:0];
    end else if (c < 5'h1E) begin
      md = oad_pkg::AM_BASEIDX;
      p = {2'b00, c[0]};
      off = w[p] + w[7];
    end else if (c == 5'h1E) begin
      md = oad_pkg::AM_PCDISP;
      off = g.programCounter + r.extWord[15:0];
    end else begin
      md = oad_pkg::AM_ADDR16;
      off = r.extWord[15:0];
    end
    // Bank follows the low two bits of the pointer; fixed banks for 1C..1F
    if (c >= 5'h1C) begin
      bs = (c == 5'h1E) ? oad_pkg::BK_CODE : oad_pkg::BK_DATA;
      bk = (c == 5'h1E) ? g.codeBankReg : g.dataBankReg;
    end else if (p[1:0] == 2'd2) begin
      bs = oad_pkg::BK_EXTRA;
      bk = g.extraDataBankReg;
    end else if (p[1:0] == 2'd3) begin
      bs = oad_pkg::BK_STACK;
      bk = g.stackSelect ? g.systemStackBank : g.userStackBank;
    end else begin
      bs = oad_pkg::BK_DATA;
      bk = g.dataBankReg;
    end
    `CHK("mode", md, res.mode)
    `CHK("isMem", 1'b1, res.isMem)
    `CHK("bank", bs, res.bank)
    `CHK("memAddr", {bk, off}, res.memAddr)
    `CHK("ptrWrite", md == oad_pkg::AM_POSTINC, res.ptrWrite)
    if (md == oad_pkg::AM_POSTINC) begin
      inc = (r.size == oad_pkg::SZ_BYTE) ? 16'h0001 :
            (r.size == oad_pkg::SZ_WORD) ? 16'h0002 : 16'h0004;
      `CHK("ptrIdx", p, res.ptrIdx)
      `CHK("ptrValue", w[p] + inc, res.ptrValue)
    end
  endtask

  // One cycle: check the result of the last request, then present the next
  task automatic step(input oad_pkg::oad_req_t r, input oad_pkg::oad_regs_t g);
    @(posedge mclk);
    #1;
    check_res(prevReq, prevRegs);
    req = r;
    regsIn = g;
    prevReq = r;
    prevRegs = g;
  endtask

  // Counts, verdict and end of run
  task automatic endOfTest();
    $display("Checks %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; requests are back to back, with one idle cycle after the implied modes and idle cycles in the random mix
  initial begin
    oad_pkg::oad_req_t  r;
    oad_pkg::oad_regs_t g;
    seed = 62689;
    errTotal = 0;
    testsRun = 0;
    mclk = 1'b0;
    rst = 1'b1;
    req = '0;
    regsIn = '0;
    prevReq = '0;
    prevRegs = '0;
    modes = '{oad_pkg::AM_BR16, oad_pkg::AM_BR24, oad_pkg::AM_IO,
              oad_pkg::AM_DIR, oad_pkg::AM_IMM, oad_pkg::AM_REG,
              oad_pkg::AM_IOBIT, oad_pkg::AM_DIRBIT, oad_pkg::AM_ADDR16,
              oad_pkg::AM_ADDRBIT};
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    // Every code with every operand size
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 32; c++) begin
        r = rand_req();
        r.eaCode = 5'(c);
        r.size = oad_pkg::oad_size_t'(2'(s));
        step(r, rand_regs());
      end
    end
    // Pointer wrap on a long post increment through word register 3, a stack bank pointer
    r = rand_req();
    r.eaCode = 5'h0F;
    r.size = oad_pkg::SZ_LONG;
    g = rand_regs();
    g.wordReg3 = 16'hFFFF;
    step(r, g);
    // Implied modes, every immediate size
    for (int k = 0; k < 40; k++) begin
      r = rand_req();
      r.implied = 1'b1;
      r.impliedMode = modes[k % 10];
      r.immSize = oad_pkg::oad_imm_t'(2'(k / 10));
      step(r, rand_regs());
    end
    step('0, rand_regs());
    // Random mix with idle gaps
    for (int n = 0; n < 800; n++) begin
      r = rand_req();
      r.implied = (($unsigned($random(seed)) % 4) == 0);
      r.impliedMode = modes[$unsigned($random(seed)) % 10];
      r.valid = (($unsigned($random(seed)) % 8) != 0);
      step(r, rand_regs());
    end
    step('0, '0);
    endOfTest();
  end
endmodule
